// >>> ttc_trigger.sv
// ttc_trigger: trigger comparator and start/stop sequencing of the sample trace
// assumes: configuration inputs are held stable by the frame controller, samples arrive
// on sampleValid at the module sampling rate, all inputs synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module ttc_trigger
  import ttc_pkg::*;
#(
  parameter int CH_COUNT = 2
)(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sampleValid,
  input wire logic [CH_COUNT*16-1:0] sampleValues,
  input wire logic [CH_COUNT*16-1:0] lowerHysteresisLimit,
  input wire logic [CH_COUNT*16-1:0] upperHysteresisLimit,
  input wire logic [15:0] triggerDesiredState,
  input wire logic [15:0] triggerSelectMask,
  input wire logic [15:0] triggerOperatorMask,
  input wire logic [15:0] traceStartOffset,
  input wire logic [15:0] traceStopPosition,
  input wire logic traceEnable,
  input wire logic [4:0] acyclicFrameBytes,
  output logic [15:0] hysteresisStatusWord,
  output logic triggerPulse,
  output logic recordActive,
  output logic [15:0] preTriggerDepth,
  output logic traceDone,
  output logic [4:0] acyclicSlotBytes
);

  // ==========================================================
  // elaboration check
  generate
    if (CH_COUNT < 1 || CH_COUNT > MAX_CH) begin : g_bad_ch
      $error("CH_COUNT must be 1 or 2");
    end
  endgenerate

  // ==========================================================
  // per channel status
  logic [STATUS_W-1:0] statusWord;
  logic [CH_COUNT-1:0] hc, rc, hp, rp;

  genvar ch;
  generate
    for (ch = 0; ch < CH_COUNT; ch++) begin : g_ch
      ttc_chan_status u_chan (
        .mclk(mclk),
        .arst_n(arst_n),
        .sampleValid(sampleValid),
        .sampleValue(sampleValues[ch*16 +: 16]),
        .lowerLimit(lowerHysteresisLimit[ch*16 +: 16]),
        .upperLimit(upperHysteresisLimit[ch*16 +: 16]),
        .hystCur(hc[ch]),
        .inRangeCur(rc[ch]),
        .hystPrev(hp[ch]),
        .inRangePrev(rp[ch])
      );
    end
  endgenerate

  always_comb begin
    statusWord = '0;
    for (int i = 0; i < CH_COUNT; i++) begin
      statusWord[CUR_BASE + i*BITS_PER_CH + HYST_POS] = hc[i];
      statusWord[CUR_BASE + i*BITS_PER_CH + RANGE_POS] = rc[i];
      statusWord[PREV_BASE + i*BITS_PER_CH + HYST_POS] = hp[i];
      statusWord[PREV_BASE + i*BITS_PER_CH + RANGE_POS] = rp[i];
    end
  end

  assign hysteresisStatusWord = statusWord;

  // ==========================================================
  // comparison
  function automatic logic cond_met(input logic [15:0] st, input logic [15:0] want,
                                    input logic [15:0] sel, input logic [15:0] ops);
    logic [15:0] match;
    logic [15:0] andSel;
    logic [15:0] orSel;
    match = ~(st ^ want);
    andSel = sel & ~ops;
    orSel = sel & ops;
    // an OR placed on an unselected bit leaves the OR group empty and neutral
    cond_met = (sel != 16'h0000) && ((match & andSel) == andSel)
               && ((orSel == 16'h0000) || ((match & orSel) != 16'h0000));
  endfunction

  logic [15:0] usedMask;
  logic condNow;
  assign usedMask = triggerSelectMask & 16'h0f0f;
  assign condNow = cond_met(statusWord, triggerDesiredState, usedMask, triggerOperatorMask);

  // status flops update on sampleValid, so compare one cycle later
  logic sampleTick_ff, nxt_sampleTick;
  logic condPrev_ff, nxt_condPrev;
  logic trigEdge;

  assign trigEdge = sampleTick_ff && condNow && !condPrev_ff;

  always_comb begin
    nxt_sampleTick = sampleValid;
    nxt_condPrev = condPrev_ff;
    if (sampleTick_ff) begin
      nxt_condPrev = condNow;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sampleTick_ff <= 1'b0;
      condPrev_ff <= 1'b0;
    end else begin
      sampleTick_ff <= nxt_sampleTick;
      condPrev_ff <= nxt_condPrev;
    end
  end

  // ==========================================================
  // start and stop sequencing
  ttc_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] cntInc;
  logic offsetNeg, offsetCont;
  logic trigger_ff, nxt_trigger;

  assign offsetCont = (traceStartOffset == START_CONTINUOUS);
  assign offsetNeg = traceStartOffset[15];
  assign cntInc = cnt_ff + 16'h0001;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_trigger = trigEdge;
    case (state_ff)
      TTC_IDLE: begin
        nxt_cnt = CNT_RESET;
        if (traceEnable) begin
          nxt_state = offsetCont ? TTC_CONT : TTC_ARMED;
        end
      end
      TTC_ARMED: begin
        nxt_cnt = CNT_RESET;
        if (trigEdge) begin
          if (offsetNeg || traceStartOffset == 16'h0000) begin
            // stop counted from the trigger sample
            nxt_state = (traceStopPosition == 16'h0000) ? TTC_DONE : TTC_RECORD;
          end else begin
            nxt_state = TTC_DELAY;
          end
        end
      end
      TTC_DELAY: begin
        if (sampleTick_ff) begin
          nxt_cnt = cntInc;
          if (cntInc == traceStartOffset) begin
            nxt_cnt = CNT_RESET;
            // stop counted from the first recorded sample
            nxt_state = (traceStopPosition == 16'h0000) ? TTC_DONE : TTC_RECORD;
          end
        end
      end
      TTC_RECORD: begin
        if (sampleTick_ff) begin
          nxt_cnt = cntInc;
          if (cntInc == traceStopPosition) begin
            nxt_state = TTC_DONE;
          end
        end
      end
      TTC_DONE: begin
        nxt_cnt = cnt_ff;
      end
      TTC_CONT: begin
        nxt_cnt = CNT_RESET;
      end
      default: begin
        nxt_state = TTC_IDLE;
      end
    endcase
    if (!traceEnable) begin
      nxt_state = TTC_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= TTC_IDLE;
      cnt_ff <= CNT_RESET;
      trigger_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      trigger_ff <= nxt_trigger;
    end
  end

  // ==========================================================
  // outputs
  // in ARMED with a negative offset the memory keeps a rolling pre-trigger window
  assign recordActive = (state_ff == TTC_RECORD) || (state_ff == TTC_CONT)
                        || (state_ff == TTC_ARMED && offsetNeg && !offsetCont);
  assign preTriggerDepth = (offsetNeg && !offsetCont) ? (16'h0000 - traceStartOffset) : 16'h0000;
  assign traceDone = (state_ff == TTC_DONE);
  assign triggerPulse = trigger_ff;

  // ==========================================================
  // acyclic frame reservation
  logic [4:0] acySize_ff, nxt_acySize;

  always_comb begin
    nxt_acySize = acySize_ff;
    // only taken while the trace is stopped; a running size is never changed
    if (!traceEnable) begin
      if (acyclicFrameBytes >= ACY_MIN_BYTES && acyclicFrameBytes <= ACY_MAX_BYTES) begin
        nxt_acySize = acyclicFrameBytes;
      end else begin
        nxt_acySize = ACY_DEFAULT_BYTES;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acySize_ff <= ACY_DEFAULT_BYTES;
    end else begin
      acySize_ff <= nxt_acySize;
    end
  end

  assign acyclicSlotBytes = acySize_ff;

  // ==========================================================
  // checks
  sequence s_trig_armed;
    (state_ff == TTC_ARMED) && traceEnable && trigEdge;
  endsequence

  property p_trig_edge;
    @(posedge mclk) disable iff (!arst_n)
      trigEdge |-> sampleTick_ff && condNow && !condPrev_ff;
  endproperty
  a_trig_edge: assert property (p_trig_edge) else $error("trigger without edge");

  property p_trig_out;
    @(posedge mclk) disable iff (!arst_n)
      trigEdge |=> triggerPulse ##1 !triggerPulse;
  endproperty
  a_trig_out: assert property (p_trig_out) else $error("trigger pulse not one cycle");

  property p_cond_value;
    @(posedge mclk) disable iff (!arst_n)
      (usedMask != 16'h0000 && (triggerOperatorMask & usedMask) == 16'h0000
       && ((statusWord ^ triggerDesiredState) & usedMask) == 16'h0000) |-> condNow;
  endproperty
  a_cond_value: assert property (p_cond_value) else $error("full AND match not seen");

  property p_and_miss;
    @(posedge mclk) disable iff (!arst_n)
      (((statusWord ^ triggerDesiredState) & usedMask & ~triggerOperatorMask) != 16'h0000)
      |-> !condNow;
  endproperty
  a_and_miss: assert property (p_and_miss) else $error("AND mismatch still fires");

  property p_neg_start;
    @(posedge mclk) disable iff (!arst_n)
      (s_trig_armed and (offsetNeg && !offsetCont && traceStopPosition != 16'h0000))
      |=> (state_ff == TTC_RECORD) && recordActive;
  endproperty
  a_neg_start: assert property (p_neg_start) else $error("early start not recording");

  property p_pos_delay;
    @(posedge mclk) disable iff (!arst_n)
      (s_trig_armed and (!offsetNeg && traceStartOffset != 16'h0000))
      |=> (state_ff == TTC_DELAY) && !recordActive && cnt_ff == 16'h0000;
  endproperty
  a_pos_delay: assert property (p_pos_delay) else $error("delayed start wrong");

  property p_stop;
    @(posedge mclk) disable iff (!arst_n)
      (state_ff == TTC_RECORD && sampleTick_ff && traceEnable && cntInc == traceStopPosition)
      |=> traceDone && !recordActive;
  endproperty
  a_stop: assert property (p_stop) else $error("recording did not stop");

  property p_cont;
    @(posedge mclk) disable iff (!arst_n)
      (state_ff == TTC_IDLE && traceEnable && offsetCont) |=> recordActive [*2];
  endproperty
  a_cont: assert property (p_cont) else $error("continuous trace not running");

  property p_disable;
    @(posedge mclk) disable iff (!arst_n)
      !traceEnable |=> state_ff == TTC_IDLE;
  endproperty
  a_disable: assert property (p_disable) else $error("trace not stopped on disable");

  property p_acy_range;
    @(posedge mclk) disable iff (!arst_n)
      traceEnable |=> acyclicSlotBytes >= ACY_MIN_BYTES && acyclicSlotBytes <= ACY_MAX_BYTES
                      && $stable(acyclicSlotBytes);
  endproperty
  a_acy_range: assert property (p_acy_range) else $error("acyclic size out of range");

endmodule : ttc_trigger
`default_nettype wire

// >>> ttc_pkg.sv
// ttc_pkg: constants and types for the trace trigger comparator
// assumes: status word layout of two channels, two bits each, current and previous cycle
package ttc_pkg;

  // ==========================================================
  // status word layout
  localparam int STATUS_W = 16;
  localparam int CUR_BASE = 0;
  localparam int PREV_BASE = 8;
  localparam int HYST_POS = 0;
  localparam int RANGE_POS = 1;
  localparam int BITS_PER_CH = 2;
  localparam int MAX_CH = 2;

  // ==========================================================
  // reset values and special codes
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] START_CONTINUOUS = 16'h8000;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // ==========================================================
  // acyclic frame reservation, in bytes
  localparam logic [4:0] ACY_MIN_BYTES = 5'h08;
  localparam logic [4:0] ACY_MAX_BYTES = 5'h1c;
  localparam logic [4:0] ACY_DEFAULT_BYTES = 5'h18;

  typedef enum logic [2:0] {
    TTC_IDLE,
    TTC_ARMED,
    TTC_DELAY,
    TTC_RECORD,
    TTC_DONE,
    TTC_CONT
  } ttc_state_t;

endpackage : ttc_pkg

// >>> ttc_chan_status.sv
// ttc_chan_status: hysteresis and in-range status of one input channel
// assumes: sampleValid pulses once per configured sampling period
`timescale 1ns/1ps
`default_nettype none
module ttc_chan_status
  import ttc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sampleValid,
  input wire logic signed [15:0] sampleValue,
  input wire logic signed [15:0] lowerLimit,
  input wire logic signed [15:0] upperLimit,
  output logic hystCur,
  output logic inRangeCur,
  output logic hystPrev,
  output logic inRangePrev
);

  // ==========================================================
  // status registers
  logic hystCur_ff, inRangeCur_ff, hystPrev_ff, inRangePrev_ff;
  logic nxt_hystCur, nxt_inRangeCur, nxt_hystPrev, nxt_inRangePrev;

  always_comb begin
    nxt_hystCur = hystCur_ff;
    nxt_inRangeCur = inRangeCur_ff;
    nxt_hystPrev = hystPrev_ff;
    nxt_inRangePrev = inRangePrev_ff;
    if (sampleValid) begin
      // between the limits the hysteresis bit keeps its last side
      if (sampleValue > upperLimit) begin
        nxt_hystCur = 1'b1;
      end else if (sampleValue < lowerLimit) begin
        nxt_hystCur = 1'b0;
      end
      nxt_inRangeCur = (sampleValue >= lowerLimit) && (sampleValue <= upperLimit);
      nxt_hystPrev = hystCur_ff;
      nxt_inRangePrev = inRangeCur_ff;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hystCur_ff <= 1'b0;
      inRangeCur_ff <= 1'b0;
      hystPrev_ff <= 1'b0;
      inRangePrev_ff <= 1'b0;
    end else begin
      hystCur_ff <= nxt_hystCur;
      inRangeCur_ff <= nxt_inRangeCur;
      hystPrev_ff <= nxt_hystPrev;
      inRangePrev_ff <= nxt_inRangePrev;
    end
  end

  assign hystCur = hystCur_ff;
  assign inRangeCur = inRangeCur_ff;
  assign hystPrev = hystPrev_ff;
  assign inRangePrev = inRangePrev_ff;

  // ==========================================================
  // checks
  property p_hyst_high;
    @(posedge mclk) disable iff (!arst_n)
      (sampleValid && sampleValue > upperLimit) |=> hystCur_ff;
  endproperty
  a_hyst_high: assert property (p_hyst_high) else $error("hysteresis bit not set above limit");

  property p_prev_copy;
    @(posedge mclk) disable iff (!arst_n)
      sampleValid |=> (hystPrev_ff == $past(hystCur_ff)) && (inRangePrev_ff == $past(inRangeCur_ff));
  endproperty
  a_prev_copy: assert property (p_prev_copy) else $error("previous status copy wrong");

endmodule : ttc_chan_status
`default_nettype wire

// >>> ttc_ctrl_model.sv
// ttc_ctrl_model: frame controller side, sample strobe and acyclic frame size
// assumes: mclk and arst_n come from the bench, trace enable is watched
`timescale 1ns/1ps
`default_nettype none
module ttc_ctrl_model #(
  parameter int SAMPLE_PERIOD = 4,
  // shortest bus cycle at standard priority: 200 us of 100 ns clocks
  parameter int BUS_CYCLE_CLKS = 2000
)(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic traceEnable,
  output logic sampleValid,
  output logic [4:0] acyclicFrameBytes
);
  int divCnt;
  int busCnt;

  initial begin
    sampleValid = 1'b0;
    acyclicFrameBytes = 5'h18;
    divCnt = 0;
    busCnt = 0;
  end

  // ==========================================================
  // sample strobe: own fixed rate, unrelated to any bus cycle
  always @(posedge mclk) begin
    #1;
    if (!arst_n) begin
      sampleValid = 1'b0;
      divCnt = 0;
      busCnt = 0;
    end else begin
      sampleValid = (divCnt == SAMPLE_PERIOD - 1);
      divCnt = (divCnt + 1) % SAMPLE_PERIOD;
      busCnt = (busCnt + 1) % BUS_CYCLE_CLKS;
    end
  end

  // ==========================================================
  // frame size only changes while the trace is stopped
  task automatic setFrame(input logic [4:0] bytesReq);
    // a new reservation only goes out at a bus cycle boundary
    do begin
      @(posedge mclk);
      #1;
    end while (busCnt != 0);
    if (traceEnable !== 1'b1) begin
      acyclicFrameBytes = bytesReq;
    end
  endtask
endmodule // ttc_ctrl_model
`default_nettype wire

// >>> tb_trace_trigger_comparator.sv
// tb_trace_trigger_comparator: self-checking bench for ttc_trigger
// assumes: ttc_pkg and ttc_ctrl_model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_trace_trigger_comparator;
  import ttc_pkg::*;
  logic mclk, arst_n, sampleValid, traceEnable, triggerPulse, recordActive, traceDone;
  logic [31:0] sampleValues, lowerHysteresisLimit, upperHysteresisLimit;
  logic [15:0] triggerDesiredState, triggerSelectMask, triggerOperatorMask;
  logic [15:0] traceStartOffset, traceStopPosition, hysteresisStatusWord, preTriggerDepth;
  logic [4:0] acyclicFrameBytes, acyclicSlotBytes;
  logic svD;
  int failures, tests_run, trigCount, recCount, cycles;

  ttc_trigger #(.CH_COUNT(2)) uut (.mclk(mclk), .arst_n(arst_n), .sampleValid(sampleValid),
    .sampleValues(sampleValues), .lowerHysteresisLimit(lowerHysteresisLimit),
    .upperHysteresisLimit(upperHysteresisLimit), .triggerDesiredState(triggerDesiredState),
    .triggerSelectMask(triggerSelectMask), .triggerOperatorMask(triggerOperatorMask),
    .traceStartOffset(traceStartOffset), .traceStopPosition(traceStopPosition),
    .traceEnable(traceEnable), .acyclicFrameBytes(acyclicFrameBytes),
    .hysteresisStatusWord(hysteresisStatusWord), .triggerPulse(triggerPulse),
    .recordActive(recordActive), .preTriggerDepth(preTriggerDepth), .traceDone(traceDone),
    .acyclicSlotBytes(acyclicSlotBytes));

  ttc_ctrl_model #(.SAMPLE_PERIOD(4)) partner (.mclk(mclk), .arst_n(arst_n),
    .traceEnable(traceEnable), .sampleValid(sampleValid),
    .acyclicFrameBytes(acyclicFrameBytes));

  // ==========================================================
  // clock, monitors, timeout
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // recorded ticks are counted from the trigger pulse onward
  always @(posedge mclk) begin
    svD <= sampleValid;
    cycles <= cycles + 1;
    if (triggerPulse === 1'b1) begin
      trigCount <= trigCount + 1;
      recCount <= 0;
    end else if (svD === 1'b1 && recordActive === 1'b1) begin
      recCount <= recCount + 1;
    end
    if (cycles == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // waits until the new values are taken, returns in the cycle after
  task automatic applySample(input logic [15:0] v0, input logic [15:0] v1);
    int n;
    @(posedge mclk);
    #1;
    sampleValues = {v1, v0};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (sampleValid !== 1'b1 && n < 20);
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic testHysteresis();
    lowerHysteresisLimit = {16'hfe0c, 16'hff9c};
    upperHysteresisLimit = {16'hff38, 16'h0064};
    applySample(16'h00c8, 16'hfed4);
    check(hysteresisStatusWord, 32'h0009);
    applySample(16'h0000, 16'hff9c);
    check(hysteresisStatusWord, 32'h0907);
    applySample(16'hff38, 16'hfda8);
    check(hysteresisStatusWord, 32'h0700);
    applySample(16'hffce, 16'hfed4);
    check(hysteresisStatusWord, 32'h000a);
    applySample(16'h0064, 16'hfe0c);
    check(hysteresisStatusWord, 32'h0a0a);
  endtask

  task automatic testCombine();
    int t0;
    lowerHysteresisLimit = {16'hff9c, 16'hff9c};
    upperHysteresisLimit = {16'h0064, 16'h0064};
    triggerDesiredState = 16'h0005;
    triggerSelectMask = 16'h0005;
    triggerOperatorMask = 16'h0010;
    applySample(16'hff38, 16'hff38);
    t0 = trigCount;
    applySample(16'h00c8, 16'hff38);
    repeat (3) @(posedge mclk);
    #1;
    check(trigCount - t0, 32'h0);
    applySample(16'h00c8, 16'h00c8);
    applySample(16'h00c8, 16'h00c8);
    repeat (3) @(posedge mclk);
    #1;
    check(trigCount - t0, 32'h1);
    triggerOperatorMask = 16'h0005;
    applySample(16'hff38, 16'hff38);
    applySample(16'hff38, 16'h00c8);
    repeat (3) @(posedge mclk);
    #1;
    check(trigCount - t0, 32'h2);
  endtask

  task automatic runTrace(input logic [15:0] offs, input logic [15:0] stop, input int expRec);
    int n;
    traceEnable = 1'b0;
    applySample(16'hff38, 16'hff38);
    applySample(16'hff38, 16'hff38);
    triggerSelectMask = 16'h0100;
    triggerDesiredState = 16'h0100;
    triggerOperatorMask = 16'h0100;
    traceStartOffset = offs;
    traceStopPosition = stop;
    @(posedge mclk);
    #1;
    traceEnable = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    check(recordActive, offs[15]);
    check(preTriggerDepth, offs[15] ? 16'(16'h0000 - offs) : 16'h0000);
    applySample(16'h00c8, 16'hff38);
    n = 0;
    while (traceDone !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    #1;
    check(traceDone, 32'h1);
    check(recordActive, 32'h0);
    check(recCount, expRec);
    traceEnable = 1'b0;
  endtask

  task automatic testContinuous();
    traceStartOffset = START_CONTINUOUS;
    @(posedge mclk);
    #1;
    traceEnable = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    check(recordActive, 32'h1);
    repeat (40) @(posedge mclk);
    #1;
    check({recordActive, traceDone}, 32'h2);
    check(preTriggerDepth, 32'h0);
    traceEnable = 1'b0;
  endtask

  task automatic testFrameSize();
    logic [4:0] req[4] = '{5'h08, 5'h1c, 5'h1e, 5'h07};
    logic [4:0] exp[4] = '{5'h08, 5'h1c, 5'h18, 5'h18};
    for (int i = 0; i < 4; i++) begin
      partner.setFrame(req[i]);
      repeat (2) @(posedge mclk);
      #1;
      check(acyclicSlotBytes, exp[i]);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    failures = 0;
    tests_run = 0;
    trigCount = 0;
    recCount = 0;
    cycles = 0;
    svD = 1'b0;
    arst_n = 1'b0;
    traceEnable = 1'b0;
    sampleValues = '0;
    lowerHysteresisLimit = '0;
    upperHysteresisLimit = '0;
    triggerDesiredState = CFG_RESET;
    triggerSelectMask = CFG_RESET;
    triggerOperatorMask = 16'h8000;
    traceStartOffset = CFG_RESET;
    traceStopPosition = CFG_RESET;
    repeat (5) @(posedge mclk);
    #1;
    check({hysteresisStatusWord, triggerPulse, recordActive, traceDone}, 32'h0);
    check(acyclicSlotBytes, ACY_DEFAULT_BYTES);
    arst_n = 1'b1;
    testHysteresis();
    testCombine();
    runTrace(16'h0002, 16'h0003, 3);
    runTrace(16'h0000, 16'h0000, 0);
    runTrace(16'hfffd, 16'h0002, 2);
    testContinuous();
    testFrameSize();
    finish_test();
  end
endmodule // tb_trace_trigger_comparator
`default_nettype wire
